// ---- hw/acf_map.svh ----
`ifndef ACF_MAP_SVH
`define ACF_MAP_SVH
// ----------------------------------------
// Frame layout
// ----------------------------------------
`define ACF_WORD_W 32
`define ACF_HDR_W 8
`define ACF_DATA_W 24
// ----------------------------------------
// Checksum
// ----------------------------------------
`define ACF_CRC_POLY 8'h07
`define ACF_CRC_PRESET 8'hFF
`define ACF_GROUP_SHORT 5'h04
`define ACF_GROUP_LONG 5'h10
`endif

// ---- hw/acf_pkg.sv ----
package acf_pkg;
  typedef enum logic [1:0] {
    ACF_CRC_OFF = 2'b00,
    ACF_CRC_EVERY4 = 2'b01,
    ACF_CRC_EVERY16 = 2'b10,
    ACF_CRC_RSVD = 2'b11
  } acf_crc_sel_e;
  typedef enum logic {
    ACF_FMT_DUAL = 1'b0,
    ACF_FMT_SINGLE = 1'b1
  } acf_lane_fmt_e;
  typedef enum logic {
    ACF_XFER_IDLE = 1'b0,
    ACF_XFER_WAIT = 1'b1
  } acf_xfer_e;
endpackage

// ---- hw/acf_crc8.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "acf_map.svh"
module acf_crc8 #(
  parameter int DATA_W = `ACF_DATA_W
) (
  input wire logic [7:0] crc_i, // Running remainder
  input wire logic [DATA_W-1:0] data_i, // Sample, msb first
  output logic [7:0] crc_o // Updated remainder
);
  always_comb begin
    logic [7:0] c;
    logic fb;
    c = crc_i;
    fb = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      fb = c[7] ^ data_i[i];
      c = {c[6:0], 1'b0} ^ (fb ? `ACF_CRC_POLY : 8'h00);
    end
    crc_o = c;
  end
endmodule
`default_nettype wire

// ---- hw/acf_framer.sv ----
// What this block does
// - Chained data moves forward one bit per rising shift clock edge.
// - Upstream serial outputs feed our two chain inputs, then leave our outputs.
// - Single-lane chaining takes its chained data from chain input a only.
// - Asynchronous start pulse is sampled and gives a clock-aligned sync-out pulse.
// - Spi sync command gives the same sync-out pulse, only in spi mode.
// - Sync-in is sampled on the rising master clock edge.
// - Each channel word is 32 bits: 8-bit header then 24-bit result.
// - Checksum insertion exists only in spi mode, picked by a select field.
// - Checksum replaces the header every 4 or every 16 samples.
// - Each channel has its own checksum over its own samples.
// - A sync pulse presets every channel accumulator to all ones.
// - Last sample of a group carries the checksum covering its own data.
// - After a checksum header the accumulator is preset again.
// - Checksum frames align across channels, counted in strobes since sync.
// - Generator polynomial is x^8 + x^2 + x + 1.
// - Message is extended by eight zeros before division.
// - Remainder after repeated aligned xor is the 8-bit checksum.
// - After each strobe fall the header goes out first, then the result.
`timescale 1ns/1ps
`default_nettype none
`include "acf_map.svh"
module acf_framer #(
  parameter int NUM_CH = 8
) (
  input wire logic CLOCK_I, // Master clock
  input wire logic RSTN_I, // Synchronous reset, low active
  input wire logic CE_I, // Clock enable
  input wire logic SERIAL_SHIFT_CLOCK_I, // Link shift clock
  input wire logic SAMPLE_VALID_I, // New conversion set, one pulse
  input wire logic [NUM_CH*`ACF_DATA_W-1:0] SAMPLE_DATA_I, // Results, channel 0 low
  input wire logic [NUM_CH*`ACF_HDR_W-1:0] SAMPLE_STATUS_I, // Status headers
  input wire logic SPI_MODE_I, // Spi control mode
  input wire logic [1:0] CRC_SELECT_I, // Checksum select field
  input wire logic SPI_SYNC_CMD_I, // Spi sync command, one pulse
  input wire logic START_N_I, // Asynchronous start pin
  input wire logic SYNC_IN_N_I, // Clock-synchronous sync pin
  input wire logic OUTPUT_LANE_FORMAT_I, // 0 two lanes, 1 lane a only
  input wire logic CHAIN_IN_A_I, // Chain data from upstream lane a
  input wire logic CHAIN_IN_B_I, // Chain data from upstream lane b
  output logic SERIAL_OUT_A_O, // Serial data lane a
  output logic SERIAL_OUT_B_O, // Serial data lane b
  output logic FRAME_READY_N_O, // Frame ready strobe, low active
  output logic SYNC_OUT_N_O, // Aligned sync pulse, low active
  output logic FRAME_DROP_O // Sample set lost, link busy
);
  localparam int WORDS_W = NUM_CH * `ACF_WORD_W;
  localparam int LANE_W = WORDS_W / 2;

  // ----------------------------------------
  // Pin synchronisers, master domain
  // ----------------------------------------
  logic start_meta_reg, start_sync_reg, start_prev_reg;
  logic fmt_meta_reg, fmt_sync_reg;
  logic sync_in_reg, sync_in_prev_reg;
  logic start_fall, spi_sync, sync_evt;

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      start_meta_reg <= 1'b1;
      start_sync_reg <= 1'b1;
      start_prev_reg <= 1'b1;
      fmt_meta_reg <= 1'b0;
      fmt_sync_reg <= 1'b0;
    end else if (CE_I) begin
      start_meta_reg <= START_N_I;
      start_sync_reg <= start_meta_reg;
      start_prev_reg <= start_sync_reg;
      fmt_meta_reg <= OUTPUT_LANE_FORMAT_I;
      fmt_sync_reg <= fmt_meta_reg;
    end
  end

  // Already aligned to the master clock, so one sampling stage
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      sync_in_reg <= 1'b1;
      sync_in_prev_reg <= 1'b1;
    end else if (CE_I) begin
      sync_in_reg <= SYNC_IN_N_I;
      sync_in_prev_reg <= sync_in_reg;
    end
  end

  assign start_fall = start_prev_reg & ~start_sync_reg;
  assign spi_sync = SPI_MODE_I & SPI_SYNC_CMD_I;
  // Release of sync-in restarts the groups
  assign sync_evt = ~sync_in_prev_reg & sync_in_reg;

  // ----------------------------------------
  // Sync-out pulse
  // ----------------------------------------
  logic sync_out_n_reg;
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      sync_out_n_reg <= 1'b1;
    end else if (CE_I) begin
      sync_out_n_reg <= ~(start_fall | spi_sync);
    end
  end
  assign SYNC_OUT_N_O = sync_out_n_reg;

  // ----------------------------------------
  // Checksum grouping
  // ----------------------------------------
  acf_pkg::acf_crc_sel_e crc_sel;
  acf_pkg::acf_xfer_e xfer_reg;
  logic crc_on, crc_slot, accept;
  logic [4:0] group_len, grp_cnt_reg;

  always_comb begin
    crc_sel = SPI_MODE_I ? acf_pkg::acf_crc_sel_e'(CRC_SELECT_I) : acf_pkg::ACF_CRC_OFF;
    crc_on = (crc_sel == acf_pkg::ACF_CRC_EVERY4) || (crc_sel == acf_pkg::ACF_CRC_EVERY16);
    group_len = (crc_sel == acf_pkg::ACF_CRC_EVERY16) ? `ACF_GROUP_LONG : `ACF_GROUP_SHORT;
  end

  assign accept = CE_I & SAMPLE_VALID_I & (xfer_reg == acf_pkg::ACF_XFER_IDLE) & ~sync_evt;
  assign crc_slot = crc_on & (grp_cnt_reg == group_len - 5'h01);

  // Counts strobes, not per-channel data, so all channels line up
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      grp_cnt_reg <= 5'h00;
    end else if (CE_I) begin
      if (sync_evt || !crc_on) begin
        grp_cnt_reg <= 5'h00;
      end else if (accept) begin
        grp_cnt_reg <= crc_slot ? 5'h00 : grp_cnt_reg + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // Per-channel accumulators and words
  // ----------------------------------------
  logic [7:0] crc_reg [NUM_CH];
  logic [7:0] crc_next [NUM_CH];
  logic [WORDS_W-1:0] word_next;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [`ACF_DATA_W-1:0] data;
    logic [`ACF_HDR_W-1:0] status;
    assign data = SAMPLE_DATA_I[ch*`ACF_DATA_W +: `ACF_DATA_W];
    assign status = SAMPLE_STATUS_I[ch*`ACF_HDR_W +: `ACF_HDR_W];

    acf_crc8 #(
      .DATA_W(`ACF_DATA_W)
    ) u_crc (
      .crc_i(crc_reg[ch]),
      .data_i(data),
      .crc_o(crc_next[ch])
    );

    always_ff @(posedge CLOCK_I) begin
      if (!RSTN_I) begin
        crc_reg[ch] <= `ACF_CRC_PRESET;
      end else if (CE_I) begin
        if (sync_evt) begin
          crc_reg[ch] <= `ACF_CRC_PRESET;
        end else if (accept) begin
          crc_reg[ch] <= crc_slot ? `ACF_CRC_PRESET : crc_next[ch];
        end
      end
    end

    // Channel 0 goes first on lane a
    assign word_next[WORDS_W-1-ch*`ACF_WORD_W -: `ACF_WORD_W] =
      {(crc_slot ? crc_next[ch] : status), data};

    a_crc_preset: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
      CE_I && sync_evt |=> crc_reg[ch] == `ACF_CRC_PRESET)
      else $error("accumulator not preset after sync");
    a_crc_regroup: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
      accept && crc_slot |=> crc_reg[ch] == `ACF_CRC_PRESET)
      else $error("accumulator not preset after checksum header");
    a_crc_chain: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
      accept && !crc_slot |=> crc_reg[ch] == $past(crc_next[ch]))
      else $error("accumulator lost a sample");
  end

  // ----------------------------------------
  // Frame hand-over to the link domain
  // ----------------------------------------
  logic [WORDS_W-1:0] frame_words_reg;
  logic frame_fmt_reg, req_tgl_reg, drop_reg;
  logic ack_meta_reg, ack_sync_reg, ack_tgl_reg;

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      frame_words_reg <= '0;
      frame_fmt_reg <= 1'b0;
    end else if (accept) begin
      frame_words_reg <= word_next;
      frame_fmt_reg <= fmt_sync_reg;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end else if (CE_I) begin
      ack_meta_reg <= ack_tgl_reg;
      ack_sync_reg <= ack_meta_reg;
    end
  end

  // Words stay put until the link side acknowledges
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      xfer_reg <= acf_pkg::ACF_XFER_IDLE;
      req_tgl_reg <= 1'b0;
    end else if (CE_I) begin
      unique case (xfer_reg)
        acf_pkg::ACF_XFER_IDLE: begin
          if (accept) begin
            req_tgl_reg <= ~req_tgl_reg;
            xfer_reg <= acf_pkg::ACF_XFER_WAIT;
          end
        end
        acf_pkg::ACF_XFER_WAIT: begin
          if (ack_sync_reg == req_tgl_reg) begin
            xfer_reg <= acf_pkg::ACF_XFER_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      drop_reg <= 1'b0;
    end else if (CE_I) begin
      drop_reg <= SAMPLE_VALID_I & (xfer_reg == acf_pkg::ACF_XFER_WAIT) & ~sync_evt;
    end
  end
  assign FRAME_DROP_O = drop_reg;

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  logic lrst_meta_reg, lrst_n_reg, lce_meta_reg, lce_reg;
  logic req_meta_reg, req_sync_reg, req_seen_reg, load;
  logic [LANE_W-1:0] sr_a_reg, sr_b_reg;
  logic out_a_reg, out_b_reg, ready_n_reg, lfmt_reg;

  // Reset and enable reach the link clock through two stages
  always_ff @(posedge SERIAL_SHIFT_CLOCK_I) begin
    lrst_meta_reg <= RSTN_I;
    lrst_n_reg <= lrst_meta_reg;
    lce_meta_reg <= CE_I;
    lce_reg <= lce_meta_reg;
  end

  always_ff @(posedge SERIAL_SHIFT_CLOCK_I) begin
    if (!lrst_n_reg) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
    end else if (lce_reg) begin
      req_meta_reg <= req_tgl_reg;
      req_sync_reg <= req_meta_reg;
    end
  end

  assign load = lce_reg & (req_sync_reg != req_seen_reg);

  always_ff @(posedge SERIAL_SHIFT_CLOCK_I) begin
    if (!lrst_n_reg) begin
      req_seen_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      lfmt_reg <= 1'b0;
    end else if (load) begin
      req_seen_reg <= req_sync_reg;
      ack_tgl_reg <= req_sync_reg;
      lfmt_reg <= frame_fmt_reg;
    end
  end

  // Own words first, upstream data follows behind them
  always_ff @(posedge SERIAL_SHIFT_CLOCK_I) begin
    if (!lrst_n_reg) begin
      sr_a_reg <= '0;
      sr_b_reg <= '0;
    end else if (load) begin
      sr_a_reg <= frame_words_reg[WORDS_W-1 -: LANE_W];
      sr_b_reg <= frame_words_reg[LANE_W-1:0];
    end else if (lce_reg) begin
      if (lfmt_reg == acf_pkg::ACF_FMT_SINGLE) begin
        sr_a_reg <= {sr_a_reg[LANE_W-2:0], sr_b_reg[LANE_W-1]};
        sr_b_reg <= {sr_b_reg[LANE_W-2:0], CHAIN_IN_A_I};
      end else begin
        sr_a_reg <= {sr_a_reg[LANE_W-2:0], CHAIN_IN_A_I};
        sr_b_reg <= {sr_b_reg[LANE_W-2:0], CHAIN_IN_B_I};
      end
    end
  end

  // Strobe leads the first header bit by one shift clock
  always_ff @(posedge SERIAL_SHIFT_CLOCK_I) begin
    if (!lrst_n_reg) begin
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
      ready_n_reg <= 1'b1;
    end else if (lce_reg) begin
      out_a_reg <= sr_a_reg[LANE_W-1];
      out_b_reg <= (lfmt_reg == acf_pkg::ACF_FMT_SINGLE) ? 1'b0 : sr_b_reg[LANE_W-1];
      ready_n_reg <= ~load;
    end
  end
  assign SERIAL_OUT_A_O = out_a_reg;
  assign SERIAL_OUT_B_O = out_b_reg;
  assign FRAME_READY_N_O = ready_n_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_start_seen;
    CE_I && start_fall;
  endsequence
  sequence s_pulse_out;
    !sync_out_n_reg ##1 sync_out_n_reg;
  endsequence

  a_start_pulse: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    s_start_seen |=> s_pulse_out)
    else $error("start pulse gave no aligned sync-out pulse");
  a_spi_gate: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    CE_I && !SPI_MODE_I && !start_fall |=> sync_out_n_reg)
    else $error("sync-out fired outside spi mode");
  a_spi_pulse: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    CE_I && SPI_MODE_I && SPI_SYNC_CMD_I |=> !sync_out_n_reg)
    else $error("spi sync command gave no sync-out pulse");
  a_sync_sample: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    CE_I && !SYNC_IN_N_I ##1 CE_I && SYNC_IN_N_I ##1 CE_I |=> grp_cnt_reg == 5'h00)
    else $error("sync-in release did not restart the group");
  a_grp_bound: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    crc_on |-> grp_cnt_reg < group_len)
    else $error("group counter ran past its length");
  a_crc_mode: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    !SPI_MODE_I |-> !crc_slot)
    else $error("checksum slot outside spi mode");
  a_header_crc: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    accept && crc_slot |=> frame_words_reg[WORDS_W-1 -: 8] == $past(crc_next[0]))
    else $error("checksum header missing in last sample of group");
  a_ready_pulse: assert property (@(posedge SERIAL_SHIFT_CLOCK_I)
    disable iff (!lrst_n_reg)
    load |=> !ready_n_reg ##1 (ready_n_reg || !lce_reg))
    else $error("frame strobe not a single low cycle");
  a_chain_shift: assert property (@(posedge SERIAL_SHIFT_CLOCK_I)
    disable iff (!lrst_n_reg)
    lce_reg && !load && lfmt_reg == acf_pkg::ACF_FMT_DUAL |=> sr_a_reg[0] == $past(CHAIN_IN_A_I))
    else $error("chain data not shifted in");
endmodule
`default_nettype wire

// ---- verification/acf_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Receiving host plus an upstream converter feeding the chain inputs
module acf_host_model #(
  parameter int NB = 72
) (
  input wire logic lclk_i, // Link shift clock
  input wire logic clear_i, // Re-arm capture, level
  input wire logic [7:0] nbits_i, // Bits to capture per lane
  input wire logic ready_n_i, // Frame ready strobe, low active
  input wire logic out_a_i, // Serial lane a
  input wire logic out_b_i, // Serial lane b
  output logic chain_a_o, // Upstream lane a
  output logic chain_b_o, // Upstream lane b
  output logic done_o // Capture complete
);
  logic a_bits[NB];
  logic b_bits[NB];
  logic ca[8];
  logic cb[8];
  logic col;
  int n;
  int k;
  logic [7:0] pat = 8'hA5;
  // ----------------------------------------
  // Upstream device
  // ----------------------------------------
  // Pattern moves every cycle so a stale line never passes for data
  always @(negedge lclk_i) begin
    pat <= {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
  end
  assign chain_a_o = pat[0];
  assign chain_b_o = pat[3];
  // ----------------------------------------
  // Capture, lane bits mid-bit on the falling edge, chain bits on the rising edge
  // ----------------------------------------
  always @(negedge lclk_i) begin
    if (clear_i) begin
      col <= 1'b0;
      n <= 0;
    end else if (!col && ready_n_i === 1'b0) begin
      col <= 1'b1;
    end else if (col && n < nbits_i) begin
      a_bits[n] <= out_a_i;
      b_bits[n] <= out_b_i;
      n <= n + 1;
    end
  end
  always @(posedge lclk_i) begin
    if (clear_i) begin
      k <= 0;
    end else if (col && k < 8) begin
      ca[k] <= chain_a_o;
      cb[k] <= chain_b_o;
      k <= k + 1;
    end
  end
  assign done_o = col && (n == int'(nbits_i));
endmodule
`default_nettype wire

// ---- verification/acf_framer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "acf_map.svh"
module acf_framer_tb_top;
  localparam int NCH = 2;
  logic clk = 1'b0, lclk = 1'b0, rstn = 1'b0, valid = 1'b0, spi = 1'b1, cmd = 1'b0;
  logic start_n = 1'b1, sync_n = 1'b1, fmt = 1'b0, clear = 1'b1, out_a, out_b, ce = 1'b1;
  logic ready_n, sync_out_n, drop, ch_a, ch_b, done;
  logic [1:0] sel = 2'b00;
  logic [7:0] nbits = 8'h28;
  logic [NCH*24-1:0] sdata = '0;
  logic [NCH*8-1:0] sstat = '0;
  logic [7:0] acc[NCH];
  int fail_count = 0, cmp_count = 0, gcnt = 0, drops = 0, cyc = 0;
  int seed = 32'h2b83;
  initial forever #2 clk = ~clk;
  initial begin
    #37;
    forever #80 lclk = ~lclk;
  end
  acf_framer #(.NUM_CH(NCH)) dut (.CLOCK_I(clk), .RSTN_I(rstn), .CE_I(ce),
    .SERIAL_SHIFT_CLOCK_I(lclk), .SAMPLE_VALID_I(valid), .SAMPLE_DATA_I(sdata),
    .SAMPLE_STATUS_I(sstat), .SPI_MODE_I(spi), .CRC_SELECT_I(sel), .SPI_SYNC_CMD_I(cmd),
    .START_N_I(start_n), .SYNC_IN_N_I(sync_n), .OUTPUT_LANE_FORMAT_I(fmt),
    .CHAIN_IN_A_I(ch_a), .CHAIN_IN_B_I(ch_b), .SERIAL_OUT_A_O(out_a),
    .SERIAL_OUT_B_O(out_b), .FRAME_READY_N_O(ready_n), .SYNC_OUT_N_O(sync_out_n),
    .FRAME_DROP_O(drop));
  acf_host_model #(.NB(72)) host (.lclk_i(lclk), .clear_i(clear), .nbits_i(nbits),
    .ready_n_i(ready_n), .out_a_i(out_a), .out_b_i(out_b), .chain_a_o(ch_a),
    .chain_b_o(ch_b), .done_o(done));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (drop === 1'b1) drops <= drops + 1;
    if (cyc == 90000) begin
      fail_count = fail_count + 1;
      finish_test();
    end
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  function automatic logic [7:0] crc24(input logic [7:0] c, input logic [23:0] d);
    logic fb;
    for (int i = 23; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0} ^ (fb ? `ACF_CRC_POLY : 8'h00);
    end
    return c;
  endfunction
  task automatic sync_pulse();
    sync_n = 1'b0;
    tick();
    sync_n = 1'b1;
    repeat (4) tick();
    gcnt = 0;
    for (int c = 0; c < NCH; c++) acc[c] = `ACF_CRC_PRESET;
  endtask
  // One conversion set through the link, optionally hit by a second set while busy
  task automatic send_frame(input bit poke);
    logic [31:0] w[NCH];
    logic [63:0] ga, gb, ea, eb;
    logic [7:0] ta, tb, xa, xb;
    logic last, d;
    int nb, t;
    nb = fmt ? 64 : 32;
    nbits = 8'(nb + 8);
    last = (sel == 2'b01 && gcnt % 4 == 3) || (sel == 2'b10 && gcnt % 16 == 15);
    for (int c = 0; c < NCH; c++) begin
      sdata[c*24+:24] = 24'($random(seed));
      sstat[c*8+:8] = 8'($random(seed));
      acc[c] = crc24(acc[c], sdata[c*24+:24]);
      w[c] = {last ? acc[c] : sstat[c*8+:8], sdata[c*24+:24]};
      if (last) acc[c] = `ACF_CRC_PRESET;
    end
    gcnt++;
    clear = 1'b1;
    repeat (300) tick();
    clear = 1'b0;
    tick();
    valid = 1'b1;
    tick();
    valid = 1'b0;
    if (poke) begin
      repeat (3) tick();
      valid = 1'b1;
      tick();
      valid = 1'b0;
      d = drop;
      tick();
      chk("frame_drop", 1, d | drop);
    end
    for (t = 0; t < 6000 && !done; t++) tick();
    chk("capture_done", 1, done);
    ga = '0;
    gb = '0;
    for (int i = 0; i < nb; i++) begin
      ga = {ga[62:0], host.a_bits[i]};
      gb = {gb[62:0], host.b_bits[i]};
    end
    for (int i = 0; i < 8; i++) begin
      ta[7-i] = host.a_bits[nb+i];
      tb[7-i] = host.b_bits[nb+i];
      xa[7-i] = host.ca[i];
      xb[7-i] = host.cb[i];
    end
    ea = fmt ? {w[0], w[1]} : {32'h0, w[0]};
    eb = fmt ? 64'h0 : {32'h0, w[1]};
    chk("lane_a_words", ea, ga);
    chk("lane_b_words", eb, gb);
    chk("chain_a_tail", xa, ta);
    if (!fmt) chk("chain_b_tail", xb, tb);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    // Link side needs several of its own edges inside reset
    repeat (130) tick();
    rstn = 1'b1;
    tick();
    chk("sync_out_idle", 1, sync_out_n);
    cmd = 1'b1;
    tick();
    cmd = 1'b0;
    chk("spi_sync_low", 0, sync_out_n);
    tick();
    chk("spi_sync_end", 1, sync_out_n);
    // Frozen clock enable must swallow a sync command
    ce = 1'b0;
    cmd = 1'b1;
    tick();
    cmd = 1'b0;
    chk("ce_freeze", 1, sync_out_n);
    tick();
    ce = 1'b1;
    repeat (2) tick();
    spi = 1'b0;
    cmd = 1'b1;
    tick();
    cmd = 1'b0;
    repeat (3) begin
      chk("spi_sync_refused", 1, sync_out_n);
      tick();
    end
    spi = 1'b1;
    start_n = 1'b0;
    for (int t = 0; t < 8 && sync_out_n !== 1'b0; t++) tick();
    chk("start_sync_low", 0, sync_out_n);
    tick();
    chk("start_sync_end", 1, sync_out_n);
    start_n = 1'b1;
    for (int m = 0; m < 3; m++) begin
      sel = (m == 0) ? 2'b01 : (m == 1) ? 2'b10 : 2'b11;
      fmt = (m == 2);
      sync_pulse();
      sync_pulse();
      for (int f = 0; f < ((m == 0) ? 8 : (m == 1) ? 16 : 2); f++) send_frame(m == 2 && f == 0);
    end
    repeat (4) tick();
    chk("drop_pulses", 1, 64'(drops));
    finish_test();
  end
endmodule
`default_nettype wire
